//--- design/dotc_defs.svh
// Register offsets, field positions, reset values and latency figures of the termination control block.
`ifndef DOTC_DEFS_SVH
`define DOTC_DEFS_SVH
`define DOTC_ADR_MR1 6'h00
`define DOTC_ADR_MR2 6'h01
`define DOTC_ADR_MR5 6'h02
`define DOTC_ADR_LAT 6'h03
`define DOTC_ADR_CTL 6'h04
`define DOTC_ADR_STS 6'h05
`define DOTC_DLL_BIT 0
`define DOTC_NOM_LSB 8
`define DOTC_WR_LSB 9
`define DOTC_DYN_A9 9
`define DOTC_DYN_A10 10
`define DOTC_CRC_BIT 12
`define DOTC_PARK_LSB 6
`define DOTC_CWL_LSB 0
`define DOTC_CL_LSB 8
`define DOTC_AL_LSB 16
`define DOTC_PL_LSB 24
`define DOTC_PRE2_BIT 0
`define DOTC_BLM_LSB 1
`define DOTC_MR1_RST 32'h0000_0001
`define DOTC_MR2_RST 32'h0000_0000
`define DOTC_MR5_RST 32'h0000_0000
`define DOTC_LAT_RST 32'h0000_0B09
`define DOTC_CTL_RST 32'h0000_0000
`define DOTC_DEPTH 64
`define DOTC_X_1T 8'h02
`define DOTC_X_2T 8'h03
`define DOTC_RD4_1T 8'h04
`define DOTC_RD4_2T 8'h05
`define DOTC_RD8_1T 8'h06
`define DOTC_RD8_2T 8'h07
`define DOTC_W4_1T 8'h04
`define DOTC_W4_1T_CRC 8'h07
`define DOTC_W4_2T 8'h05
`define DOTC_W4_2T_CRC 8'h08
`define DOTC_W8_1T 8'h06
`define DOTC_W8_1T_CRC 8'h07
`define DOTC_W8_2T 8'h07
`define DOTC_W8_2T_CRC 8'h08
`endif

//--- design/dotc_pkg.sv
// Types shared by the termination control block.
package dotc_pkg;
	typedef enum logic [2:0] {TERM_HIZ, TERM_PARK, TERM_NOM, TERM_WR, TERM_RDOFF} dotc_term_t;
	typedef enum logic [1:0] {BLM_BL8, BLM_OTF, BLM_BC4, BLM_RSVD} dotc_blm_t;
	typedef logic [2:0] dotc_rtt_t;
endpackage

//--- design/dotc_top.sv
// On-die termination timing control with a classic Wishbone register slave.
`timescale 1ns/1ps
`include "dotc_defs.svh"

// Notes on behaviour
// - Clock-counted termination timing when DLL locked.
// - Synchronous timing also in power-down states.
// - RTT_NOM follows ODT after direct latencies.
// - Direct latencies are WL minus two/three.
// - Read turns termination off after RODTLoff.
// - BC4 read restores park RODTLoff plus 4/5.
// - BL8 read restores park RODTLoff plus 6/7.
// - No termination while driving read data.
// - Dynamic termination on when MR2 A9/A10 set.
// - Values from MR1, MR2, MR5 fields.
// - Without writes, ODT selects nominal or park.
// - Write selects RTT_WR after ODTLcnw.
// - RTT_WR drops after ODTLcwn8 or ODTLcwn4.
// - Write end latency shifts with CRC/preamble.
// - No write switching in DLL-off mode.
// - ODTLcnw is WL minus two/three.
// - ODTLcwn4/8 offsets per preamble and CRC.
// - Priority: read off, write, nominal, park.
// - Read off lasts BL/2 plus X.
module dotc_top (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Wishbone slave.
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	// DRAM side inputs sampled on the DRAM clock.
	input wire logic dll_locked_i,
	input wire logic odt_i,
	input wire logic cmd_wr_i,
	input wire logic cmd_rd_i,
	input wire logic cmd_bc4_i,
	// Termination outputs.
	output dotc_pkg::dotc_term_t term_o,
	output dotc_pkg::dotc_rtt_t rtt_o
);
	import dotc_pkg::*;

	localparam int DEPTH = `DOTC_DEPTH;

	logic [31:0] mr1_r;
	logic [31:0] mr2_r;
	logic [31:0] mr5_r;
	logic [31:0] lat_r;
	logic [31:0] ctl_r;
	logic ack_r;
	logic [31:0] dat_r;
	logic [31:0] rd_nxt;
	logic [DEPTH-1:0] odt_hist_r;
	logic [DEPTH-1:0] wr_hist_r;
	logic [DEPTH-1:0] wr4_hist_r;
	logic [DEPTH-1:0] rd_hist_r;
	logic [DEPTH-1:0] rd4_hist_r;
	logic odt_now_r;
	dotc_term_t term_r;
	dotc_term_t term_nxt;
	dotc_rtt_t rtt_r;
	dotc_rtt_t rtt_nxt;
	logic sync_mode;
	logic dyn_en;
	logic pre2;
	logic crc_en;
	dotc_blm_t blm;
	dotc_rtt_t nom_val;
	dotc_rtt_t wr_val;
	dotc_rtt_t park_val;
	logic [7:0] x_lat;
	logic [7:0] wl;
	logic [7:0] rl;
	logic [7:0] dodtl;
	logic [7:0] cnw;
	logic [7:0] cwn4;
	logic [7:0] cwn8;
	logic [7:0] roff;
	logic [7:0] rlen4;
	logic [7:0] rlen8;
	logic nom_on;
	logic wr_on;
	logic rd_off;
	logic bus_req;
	logic is_bc4;

	// Merges write data into a register under the byte enables.
	function automatic logic [31:0] dotc_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] sel);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				res[b*8 +: 8] = wd[b*8 +: 8];
			end
		end
		return res;
	endfunction

	// Picks a six-bit latency field out of the latency register.
	function automatic logic [7:0] dotc_field(input logic [31:0] reg_v, input int lsb);
		return {2'b00, reg_v[lsb +: 6]};
	endfunction

	// True when age k lies in the window starting at lo and lasting len cycles.
	function automatic logic dotc_in_win(input logic [7:0] k, input logic [7:0] lo, input logic [7:0] len);
		return (k >= lo) && ({1'b0, k} < ({1'b0, lo} + {1'b0, len}));
	endfunction

	// Takes the preamble term off a latency; a result under one cycle is held at one,
	// so that a small programmed latency can never wrap round to a huge count.
	function automatic logic [7:0] dotc_floor1(input logic [7:0] base, input logic [7:0] x);
		return (base > x) ? (base - x) : 8'h01;
	endfunction

	// Mode register views.
	assign nom_val = lat_zero_guard(mr1_r[`DOTC_NOM_LSB +: 3]);
	assign wr_val = mr2_r[`DOTC_WR_LSB +: 3];
	assign park_val = mr5_r[`DOTC_PARK_LSB +: 3];
	assign dyn_en = mr2_r[`DOTC_DYN_A9] | mr2_r[`DOTC_DYN_A10];
	assign crc_en = mr2_r[`DOTC_CRC_BIT];
	assign pre2 = ctl_r[`DOTC_PRE2_BIT];
	assign blm = dotc_blm_t'(ctl_r[`DOTC_BLM_LSB +: 2]);

	// Pass-through kept as a function so that the nominal field reads plainly.
	function automatic dotc_rtt_t lat_zero_guard(input logic [2:0] v);
		return v;
	endfunction

	// Power-down and bank states do not matter; only the DLL decides the timing mode.
	assign sync_mode = mr1_r[`DOTC_DLL_BIT] & dll_locked_i;

	// Latency arithmetic from the programmed CWL, CL, AL and PL.
	assign x_lat = pre2 ? `DOTC_X_2T : `DOTC_X_1T;
	assign wl = dotc_field(lat_r, `DOTC_CWL_LSB) + dotc_field(lat_r, `DOTC_AL_LSB) + dotc_field(lat_r, `DOTC_PL_LSB);
	assign rl = dotc_field(lat_r, `DOTC_CL_LSB) + dotc_field(lat_r, `DOTC_AL_LSB) + dotc_field(lat_r, `DOTC_PL_LSB);
	assign dodtl = dotc_floor1(wl, x_lat);
	assign cnw = dotc_floor1(wl, x_lat);
	assign roff = dotc_floor1(rl, x_lat);

	// Write end offsets over ODTLcnw for the four preamble and CRC cases.
	always_comb begin
		case ({pre2, crc_en})
			2'b00: begin
				cwn4 = cnw + `DOTC_W4_1T;
				cwn8 = cnw + `DOTC_W8_1T;
			end
			2'b01: begin
				cwn4 = cnw + `DOTC_W4_1T_CRC;
				cwn8 = cnw + `DOTC_W8_1T_CRC;
			end
			2'b10: begin
				cwn4 = cnw + `DOTC_W4_2T;
				cwn8 = cnw + `DOTC_W8_2T;
			end
			default: begin
				cwn4 = cnw + `DOTC_W4_2T_CRC;
				cwn8 = cnw + `DOTC_W8_2T_CRC;
			end
		endcase
	end

	// Read disable lengths are BL/2 plus X.
	assign rlen4 = pre2 ? `DOTC_RD4_2T : `DOTC_RD4_1T;
	assign rlen8 = pre2 ? `DOTC_RD8_2T : `DOTC_RD8_1T;

	// Burst chop is fixed by mode or taken from the command on the fly.
	always_comb begin
		case (blm)
			BLM_BC4: is_bc4 = 1'b1;
			BLM_OTF: is_bc4 = cmd_bc4_i;
			default: is_bc4 = 1'b0;
		endcase
	end

	// Histories of ODT samples; bit j holds the edge j+1 cycles before the current one.
	// Sixty-four samples are kept, so a direct latency beyond that leaves nominal off.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			odt_hist_r <= '0;
			odt_now_r <= 1'b0;
		end else begin
			odt_hist_r <= {odt_hist_r[DEPTH-2:0], odt_i};
			odt_now_r <= odt_i;
		end
	end

	// Write history; writes are only tracked while dynamic termination may act.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wr_hist_r <= '0;
			wr4_hist_r <= '0;
		end else begin
			wr_hist_r <= {wr_hist_r[DEPTH-2:0], cmd_wr_i & dyn_en & sync_mode};
			wr4_hist_r <= {wr4_hist_r[DEPTH-2:0], is_bc4};
		end
	end

	// Read history with the burst chop of each read.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rd_hist_r <= '0;
			rd4_hist_r <= '0;
		end else begin
			rd_hist_r <= {rd_hist_r[DEPTH-2:0], cmd_rd_i};
			rd4_hist_r <= {rd4_hist_r[DEPTH-2:0], is_bc4};
		end
	end

	// Nominal termination follows ODT delayed by the direct latency, or by one cycle through odt_now_r with the DLL off.
	always_comb begin
		if (!sync_mode) begin
			nom_on = odt_now_r;
		end else if (dodtl <= 8'(DEPTH)) begin
			nom_on = odt_hist_r[6'(dodtl - 8'h01)];
		end else begin
			nom_on = 1'b0;
		end
	end

	// Write and read windows, each counted from its own command edge.
	// One history bit per edge lets back-to-back commands overlap without losing either window.
	always_comb begin
		logic [7:0] age;
		age = 8'h00;
		wr_on = 1'b0;
		rd_off = 1'b0;
		for (int j = 0; j < DEPTH; j++) begin
			age = 8'(j + 1);
			if (wr_hist_r[j] && dotc_in_win(age, cnw, (wr4_hist_r[j] ? cwn4 : cwn8) - cnw)) begin
				wr_on = 1'b1;
			end
			if (rd_hist_r[j] && dotc_in_win(age, roff, rd4_hist_r[j] ? rlen4 : rlen8)) begin
				rd_off = 1'b1;
			end
		end
	end

	// State selection in priority order.
	always_comb begin
		if (rd_off) begin
			term_nxt = TERM_RDOFF;
		end else if (wr_on) begin
			term_nxt = TERM_WR;
		end else if (nom_on && (nom_val != 3'b000)) begin
			term_nxt = TERM_NOM;
		end else if (park_val != 3'b000) begin
			term_nxt = TERM_PARK;
		end else begin
			term_nxt = TERM_HIZ;
		end
	end

	// Resistance code for the chosen state.
	always_comb begin
		case (term_nxt)
			TERM_WR: rtt_nxt = wr_val;
			TERM_NOM: rtt_nxt = nom_val;
			TERM_PARK: rtt_nxt = park_val;
			default: rtt_nxt = 3'b000;
		endcase
	end

	// Registered termination outputs.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			term_r <= TERM_HIZ;
			rtt_r <= 3'b000;
		end else begin
			term_r <= term_nxt;
			rtt_r <= rtt_nxt;
		end
	end

	// The termination state and code leave the block straight from their flip-flops.
	assign term_o = term_r;
	assign rtt_o = rtt_r;

	// A request is answered once, in the cycle after it is seen.
	assign bus_req = cyc_i & stb_i & ~ack_r;

	// Register writes under byte enables.
	// Writes to unmapped words and to the status word are acknowledged and dropped.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mr1_r <= `DOTC_MR1_RST;
			mr2_r <= `DOTC_MR2_RST;
			mr5_r <= `DOTC_MR5_RST;
			lat_r <= `DOTC_LAT_RST;
			ctl_r <= `DOTC_CTL_RST;
		end else if (bus_req && we_i) begin
			case (adr_i[7:2])
				`DOTC_ADR_MR1: mr1_r <= dotc_merge(mr1_r, dat_i, sel_i);
				`DOTC_ADR_MR2: mr2_r <= dotc_merge(mr2_r, dat_i, sel_i);
				`DOTC_ADR_MR5: mr5_r <= dotc_merge(mr5_r, dat_i, sel_i);
				`DOTC_ADR_LAT: lat_r <= dotc_merge(lat_r, dat_i, sel_i);
				`DOTC_ADR_CTL: ctl_r <= dotc_merge(ctl_r, dat_i, sel_i);
				default: ;
			endcase
		end
	end

	// Read data mux; the status word shows the live termination state.
	always_comb begin
		case (adr_i[7:2])
			`DOTC_ADR_MR1: rd_nxt = mr1_r;
			`DOTC_ADR_MR2: rd_nxt = mr2_r;
			`DOTC_ADR_MR5: rd_nxt = mr5_r;
			`DOTC_ADR_LAT: rd_nxt = lat_r;
			`DOTC_ADR_CTL: rd_nxt = ctl_r;
			`DOTC_ADR_STS: rd_nxt = {23'h00_0000, sync_mode, dyn_en, dll_locked_i, rtt_r, term_r};
			default: rd_nxt = 32'h0000_0000;
		endcase
	end

	// Acknowledge and read data registers.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
			dat_r <= 32'h0000_0000;
		end else begin
			ack_r <= bus_req;
			if (bus_req && !we_i) begin
				dat_r <= rd_nxt;
			end
		end
	end

	// Bus answer and read data come straight from their flip-flops.
	assign ack_o = ack_r;
	assign dat_o = dat_r;
endmodule

//--- dv/dotc_props.sv
// Port checker for the termination control block.
`timescale 1ns/1ps
module dotc_props (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Bus.
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [7:0] adr_i,
	input wire logic [31:0] dat_i,
	input wire logic ack_o,
	// Termination link.
	input wire logic dll_locked_i,
	input wire logic odt_i,
	input wire logic cmd_rd_i,
	input wire logic cmd_bc4_i,
	input wire dotc_pkg::dotc_term_t term_o,
	input wire dotc_pkg::dotc_rtt_t rtt_o
);
	import dotc_pkg::*;
	logic [31:0] lat_r;
	logic [2:0] ctl_r;
	logic [3:0] stab_r;
	logic dflt;
	logic bl8;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Mirrors full-word writes of the latency and control words.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lat_r <= 32'h0000_0B09;
			ctl_r <= 3'h0;
		end else if (ack_o && we_i && adr_i[7:2] == 6'h03) begin
			lat_r <= dat_i;
		end else if (ack_o && we_i && adr_i[7:2] == 6'h04) begin
			ctl_r <= dat_i[2:0];
		end
	end
	// Counts quiet cycles since a write or loss of lock, so old histories have drained.
	always_ff @(posedge clk_i) begin
		if (rst_i || !dll_locked_i || (ack_o && we_i)) begin
			stab_r <= 4'h0;
		end else if (stab_r != 4'hF) begin
			stab_r <= stab_r + 4'h1;
		end
	end
	// Timing checks hold for CWL 9, CL 11, no added latency and the short preamble.
	assign dflt = stab_r == 4'hF && lat_r == 32'h0000_0B09 && !ctl_r[0];
	assign bl8 = ctl_r[2:1] != 2'h2 && !(ctl_r[2:1] == 2'h1 && cmd_bc4_i);
	sequence s_rd_lone;
		cmd_rd_i && dflt && bl8 ##1 !cmd_rd_i [*8];
	endsequence
	sequence s_rd_gap;
		(term_o == TERM_RDOFF) [*6] ##1 term_o != TERM_RDOFF;
	endsequence
	chk_ack_once: assert property (ack_o |=> !ack_o) else $error("ack too long");
	chk_ack_reply: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack missing");
	chk_ack_cause: assert property (!(cyc_i && stb_i) |=> !ack_o) else $error("stray ack");
	chk_rtt_zero: assert property (term_o inside {TERM_HIZ, TERM_RDOFF} |-> rtt_o == 3'h0)
		else $error("code while open");
	chk_reset_idle: assert property ($fell(rst_i) |-> term_o == TERM_HIZ && rtt_o == 3'h0 && !ack_o)
		else $error("reset state");
	chk_read_off: assert property (cmd_rd_i && dflt |-> ##10 (term_o == TERM_RDOFF) [*4])
		else $error("read off late");
	chk_read_end: assert property (s_rd_lone |-> ##2 s_rd_gap) else $error("read window");
	chk_nom_src: assert property (dflt && term_o == TERM_NOM |-> $past(odt_i, 8))
		else $error("nominal early");
endmodule
bind dotc_top dotc_props u_props (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
	.adr_i(adr_i), .dat_i(dat_i), .ack_o(ack_o), .dll_locked_i(dll_locked_i), .odt_i(odt_i),
	.cmd_rd_i(cmd_rd_i), .cmd_bc4_i(cmd_bc4_i), .term_o(term_o), .rtt_o(rtt_o));

//--- dv/dotc_ctrl_model.sv
// Controller model driving the termination pin and command strobes.
`timescale 1ns/1ps
module dotc_ctrl_model (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_i,
	// Request: 0 pin pulse, 1 write, 2 read, 3 write with pin high.
	input wire logic go_i,
	input wire logic [1:0] kind_i,
	input wire logic bc4_i,
	// Pins.
	output logic odt_o,
	output logic wr_o,
	output logic rd_o,
	output logic bc4_o
);
	logic [3:0] cnt_r;
	// Holds the pin high for twelve cycles, above every hold minimum.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt_r <= 4'h0;
		end else if (go_i && (kind_i == 2'h0 || kind_i == 2'h3)) begin
			cnt_r <= 4'hC;
		end else if (cnt_r != 4'h0) begin
			cnt_r <= cnt_r - 4'h1;
		end
	end
	assign odt_o = cnt_r != 4'h0;
	// Command strobes; the burst flag flips when no command qualifies it.
	always_ff @(posedge clk_i) begin
		wr_o <= go_i && kind_i[0];
		rd_o <= go_i && kind_i == 2'h2;
		bc4_o <= go_i ? bc4_i : ~bc4_o;
	end
endmodule

//--- dv/test_dram_odt_timing_control.sv
// Self-checking bench for the termination control block.
`timescale 1ns/1ps
module test_dram_odt_timing_control;
	import dotc_pkg::*;
	typedef struct {logic [2:0] c; logic [3:0] m; logic a; logic [1:0] k; logic b; int n;} dotc_row_t;
	// Control, write field, added latency, request, burst flag, window length.
	dotc_row_t rows [18] = '{'{3'h0, 4'h1, 1'b0, 2'h0, 1'b0, 12}, '{3'h1, 4'h1, 1'b1, 2'h0, 1'b0, 12},
		'{3'h6, 4'h1, 1'b0, 2'h1, 1'b0, 6}, '{3'h4, 4'h1, 1'b0, 2'h1, 1'b0, 4},
		'{3'h0, 4'h9, 1'b0, 2'h1, 1'b0, 7}, '{3'h4, 4'h9, 1'b0, 2'h1, 1'b0, 7},
		'{3'h1, 4'h1, 1'b0, 2'h1, 1'b0, 7}, '{3'h5, 4'h1, 1'b0, 2'h1, 1'b0, 5},
		'{3'h1, 4'h9, 1'b0, 2'h1, 1'b0, 8}, '{3'h5, 4'h9, 1'b0, 2'h1, 1'b0, 8},
		'{3'h2, 4'h1, 1'b0, 2'h1, 1'b1, 4}, '{3'h2, 4'h1, 1'b1, 2'h1, 1'b0, 6},
		'{3'h0, 4'h1, 1'b0, 2'h2, 1'b0, 6}, '{3'h4, 4'h1, 1'b0, 2'h2, 1'b0, 4},
		'{3'h1, 4'h1, 1'b0, 2'h2, 1'b0, 7}, '{3'h5, 4'h1, 1'b0, 2'h2, 1'b0, 5},
		'{3'h2, 4'h1, 1'b1, 2'h2, 1'b1, 4}, '{3'h0, 4'h2, 1'b0, 2'h3, 1'b0, 6}};
	logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, dll_locked_i, go, gb, odt, wr, rd, b4;
	logic [1:0] gk;
	logic [7:0] adr_i;
	logic [31:0] dat_i, dat_o, q;
	dotc_term_t term_o;
	dotc_rtt_t rtt_o;
	dotc_term_t et [4] = '{TERM_NOM, TERM_WR, TERM_RDOFF, TERM_WR};
	int fails, samples_checked, d, n;
	dotc_top dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
		.sel_i(4'hF), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .dll_locked_i(dll_locked_i), .odt_i(odt),
		.cmd_wr_i(wr), .cmd_rd_i(rd), .cmd_bc4_i(b4), .term_o(term_o), .rtt_o(rtt_o));
	dotc_ctrl_model ctl (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .kind_i(gk), .bc4_i(gb), .odt_o(odt),
		.wr_o(wr), .rd_o(rd), .bc4_o(b4));
	// Counts a compare and reports a mismatch.
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// One classic bus cycle; read data is taken at the acknowledging edge.
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= v;
		do @(posedge clk_i); while (ack_o !== 1'b1);
		q = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
	endtask
	// Asks the controller model for one request.
	task automatic fire(input logic [1:0] k, input logic b);
		@(posedge clk_i);
		go <= 1'b1;
		gk <= k;
		gb <= b;
		@(posedge clk_i);
		go <= 1'b0;
	endtask
	// Measures latency to a state, its code and how long it lasts.
	task automatic meas(input dotc_term_t e, input logic [2:0] r, input int l, input int w);
		#1;
		for (d = 0; term_o !== e && d < 60; d++) begin
			@(posedge clk_i);
			#1;
		end
		chk(rtt_o, r);
		for (n = 0; term_o === e && n < 20; n++) begin
			@(posedge clk_i);
			#1;
		end
		chk(d - 1, l);
		chk(n, w);
	endtask
	// Prints the counts and the verdict, then stops.
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// Clock at 25 MHz.
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end
	// Cuts a hung run short.
	initial begin
		repeat (9000) @(posedge clk_i);
		fails++;
		wrap_up();
	end
	// Main sequence.
	initial begin
		{rst_i, dll_locked_i, cyc_i, stb_i, we_i, go, gb, gk, adr_i, dat_i} = {2'h3, 47'h0};
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(1'b0, 8'h00, 32'h0000_0000);
		chk(q, 32'h0000_0001);
		wb(1'b0, 8'h0C, 32'h0000_0000);
		chk(q, 32'h0000_0B09);
		wb(1'b1, 8'h3C, 32'hFFFF_FFFF);
		wb(1'b0, 8'h3C, 32'h0000_0000);
		chk(q, 32'h0000_0000);
		wb(1'b1, 8'h00, 32'h0000_0201);
		wb(1'b1, 8'h08, 32'h0000_0100);
		repeat (3) @(posedge clk_i);
		#1 chk({term_o, rtt_o}, {TERM_PARK, 3'h4});
		wb(1'b0, 8'h14, 32'h0000_0000);
		chk(q, 32'h0000_0161);
		$display("register test done");
		foreach (rows[i]) begin
			wb(1'b1, 8'h04, {19'h0, rows[i].m, 9'h0});
			wb(1'b1, 8'h0C, rows[i].a ? 32'h000A_0B09 : 32'h0000_0B09);
			wb(1'b1, 8'h10, {29'h0, rows[i].c});
			repeat (20) @(posedge clk_i);
			fire(rows[i].k, rows[i].b);
			meas(et[rows[i].k], rows[i].k == 2'h0 ? 3'h2 : rows[i].k == 2'h2 ? 3'h0 : rows[i].m[2:0],
				(rows[i].k == 2'h2 ? 11 : 9) + (rows[i].a ? 10 : 0) - (rows[i].c[0] ? 3 : 2), rows[i].n);
		end
		$display("table test done");
		fire(2'h2, 1'b0);
		repeat (2) @(posedge clk_i);
		fire(2'h2, 1'b0);
		meas(TERM_RDOFF, 3'h0, 5, 10);
		for (int j = 0; j < 2; j++) begin
			wb(1'b1, 8'h04, j ? 32'h0000_0200 : 32'h0000_0000);
			dll_locked_i <= j == 0;
			fire(2'h1, 1'b0);
			for (n = 0, d = 0; d < 30; d++) begin
				@(posedge clk_i);
				#1 n += term_o === TERM_WR;
			end
			d = 0;
			chk(n, 0);
		end
		dll_locked_i <= 1'b1;
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		#1 chk(term_o, TERM_HIZ);
		wb(1'b0, 8'h0C, 32'h0000_0000);
		chk(q, 32'h0000_0B09);
		wb(1'b0, 8'h00, 32'h0000_0000);
		chk(q, 32'h0000_0001);
		$display("awkward test done");
		wrap_up();
	end
endmodule
